// ### verilog/pib_port_intensity_bank.sv
// Per-port PWM intensity register bank for ports 0 to 7
// What this block does
// - Register 0x10 holds port 1 level in D7..D4 and port 0 in D3..D0.
// - Reading an intensity register returns both fields exactly as held before any write in the same cycle.
// - Register 0x11 holds port 3 upper nibble and port 2 lower nibble.
// - Register 0x12 holds port 5 upper nibble and port 4 lower nibble.
// - Register 0x13 holds port 7 upper nibble and port 6 lower nibble.
// - Code 0000 gives one sixteenth duty; each step adds one sixteenth.
// - Code 1111 gives full duty: static level, no PWM switching.
// - Only the new addresses are claimed; other addresses behave unchanged.
// - After power-up the PWM features stay off, like the legacy expanders.
// - Master level zero stops PWM; all outputs stay static.
`timescale 1ns/1ps
module pib_port_intensity_bank #(
  parameter int SLOT_CYCLES = pib_pkg::PIB_SLOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [pib_pkg::PIB_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [pib_pkg::PIB_DATA_W-1:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [pib_pkg::PIB_DATA_W-1:0] reg_rd_data_q,
  output logic reg_rd_hit_q,
  input wire logic [3:0] master_level,
  input wire logic [pib_pkg::PIB_PORTS-1:0] port_level,
  output logic [pib_pkg::PIB_PORTS-1:0] port_drive_q
);
  import pib_pkg::*;

  pib_pair_t pair_q [PIB_PAIRS];
  pib_pair_t pair_d [PIB_PAIRS];
  logic [7:0] rd_data_d;
  logic rd_hit_d;
  logic [7:0] drive_d;
  logic [3:0] slot_q;
  logic pwm_run;

  // Maps an address code to a pair index; only 0x10..0x13 are claimed
  function automatic logic pair_hit(input logic [7:0] addr);
    pair_hit = (addr >= PIB_ADDR_PAIR_1_0) && (addr <= PIB_ADDR_PAIR_7_6);
  endfunction : pair_hit

  function automatic logic [1:0] pair_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = 8'(addr - PIB_ADDR_PAIR_1_0);
    pair_index = diff[1:0];
  endfunction : pair_index

  // Odd port sits in the upper nibble, even port in the lower one
  function automatic logic [3:0] port_code(input pib_pair_t pr, input logic upper);
    port_code = upper ? pr[PIB_HI_LSB +: PIB_LEVEL_W] : pr[PIB_LO_LSB +: PIB_LEVEL_W];
  endfunction : port_code

  assign pwm_run = (master_level != PIB_MASTER_OFF);

  pib_slot_if slot_if ();

  assign slot_if.run = pwm_run;
  assign slot_q = slot_if.slot_q;

  pib_slot_counter #(
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_slot (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .slot_bus(slot_if.counter)
  );

  always_comb begin
    for (int i = 0; i < PIB_PAIRS; i++) begin
      pair_d[i] = pair_q[i];
    end
    if (reg_wr_en && pair_hit(reg_addr)) begin
      pair_d[pair_index(reg_addr)] = reg_wr_data;
    end
  end

  always_comb begin
    rd_hit_d = 1'b0;
    rd_data_d = reg_rd_data_q;
    if (reg_rd_en) begin
      rd_hit_d = pair_hit(reg_addr);
      // Unclaimed codes answer zero and no hit, leaving them to the legacy map
      rd_data_d = pair_hit(reg_addr) ? pair_q[pair_index(reg_addr)] : 8'h00;
    end
  end

  always_comb begin
    logic [3:0] code;
    code = 4'h0;
    drive_d = 8'h00;
    for (int p = 0; p < PIB_PORTS; p++) begin
      code = port_code(pair_q[p/2], p[0]);
      if (!pwm_run || code == PIB_LEVEL_STATIC) begin
        drive_d[p] = port_level[p];
      end else begin
        // Active for slots 0..code, i.e. code+1 of sixteen slots
        drive_d[p] = port_level[p] & (slot_q <= code);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      // Static codes at power-up keep the PWM feature invisible to legacy software
      for (int i = 0; i < PIB_PAIRS; i++) begin
        pair_q[i] <= PIB_PAIR_RESET;
      end
      reg_rd_data_q <= 8'h00;
      reg_rd_hit_q <= 1'b0;
      port_drive_q <= 8'h00;
    end else begin
      for (int i = 0; i < PIB_PAIRS; i++) begin
        pair_q[i] <= pair_d[i];
      end
      reg_rd_data_q <= rd_data_d;
      reg_rd_hit_q <= rd_hit_d;
      port_drive_q <= drive_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_write_0x13;
    reg_wr_en && reg_addr == PIB_ADDR_PAIR_7_6;
  endsequence

  sequence s_read_0x13;
    reg_rd_en && !reg_wr_en && reg_addr == PIB_ADDR_PAIR_7_6;
  endsequence

  property p_store_pair0;
    (reg_wr_en && reg_addr == PIB_ADDR_PAIR_1_0) |=> (pair_q[0] == $past(reg_wr_data));
  endproperty
  a_store_pair0: assert property (p_store_pair0) else $error("0x10 write not stored");

  property p_store_pair1;
    (reg_wr_en && reg_addr == PIB_ADDR_PAIR_3_2) |=> (pair_q[1] == $past(reg_wr_data));
  endproperty
  a_store_pair1: assert property (p_store_pair1) else $error("0x11 write not stored");

  property p_store_pair2;
    (reg_wr_en && reg_addr == PIB_ADDR_PAIR_5_4) |=> (pair_q[2] == $past(reg_wr_data));
  endproperty
  a_store_pair2: assert property (p_store_pair2) else $error("0x12 write not stored");

  property p_store_pair3;
    s_write_0x13 |=> (pair_q[3] == $past(reg_wr_data));
  endproperty
  a_store_pair3: assert property (p_store_pair3) else $error("0x13 write not stored");

  property p_read_pair0;
    (reg_rd_en && reg_addr == PIB_ADDR_PAIR_1_0) |=>
      (reg_rd_hit_q && reg_rd_data_q == $past(pair_q[0]));
  endproperty
  a_read_pair0: assert property (p_read_pair0) else $error("0x10 readback differs");

  // Hit is high only in the cycle after a read strobe, so it stays high one cycle for each cycle that reg_rd_en is held on 0x10..0x13
  property p_hit_pulse;
    !reg_rd_en |=> !reg_rd_hit_q;
  endproperty
  a_hit_pulse: assert property (p_hit_pulse) else $error("read hit without a read");

  property p_rd_hold;
    !reg_rd_en |=> $stable(reg_rd_data_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

  property p_pair_hold;
    !reg_wr_en |=> (pair_q[0] == $past(pair_q[0]) && pair_q[1] == $past(pair_q[1]) &&
      pair_q[2] == $past(pair_q[2]) && pair_q[3] == $past(pair_q[3]));
  endproperty
  a_pair_hold: assert property (p_pair_hold) else $error("level changed without a write");

  property p_write_read;
    s_write_0x13 ##1 s_read_0x13 |=> (reg_rd_hit_q && reg_rd_data_q == $past(reg_wr_data, 2));
  endproperty
  a_write_read: assert property (p_write_read) else $error("0x13 readback differs");

  property p_unclaimed_read;
    (reg_rd_en && !pair_hit(reg_addr)) |=> (!reg_rd_hit_q && reg_rd_data_q == 8'h00);
  endproperty
  a_unclaimed_read: assert property (p_unclaimed_read) else $error("foreign address claimed");

  property p_unclaimed_write;
    (reg_wr_en && !pair_hit(reg_addr)) |=> (pair_q[0] == $past(pair_q[0]) &&
      pair_q[1] == $past(pair_q[1]) && pair_q[2] == $past(pair_q[2]) &&
      pair_q[3] == $past(pair_q[3]));
  endproperty
  a_unclaimed_write: assert property (p_unclaimed_write) else $error("foreign write stored");

  property p_master_off;
    !pwm_run |=> (port_drive_q == $past(port_level));
  endproperty
  a_master_off: assert property (p_master_off) else $error("PWM active with master off");

  property p_static_port0;
    (pair_q[0][3:0] == PIB_LEVEL_STATIC) |=> (port_drive_q[0] == $past(port_level[0]));
  endproperty
  a_static_port0: assert property (p_static_port0) else $error("static code switched");

  property p_static_port1;
    (pair_q[0][7:4] == PIB_LEVEL_STATIC) |=> (port_drive_q[1] == $past(port_level[1]));
  endproperty
  a_static_port1: assert property (p_static_port1) else $error("port 1 static switched");

  // A port whose level is off must never sink, whatever its code or slot
  property p_level_gate;
    1'b1 |=> ((port_drive_q & ~$past(port_level)) == 8'h00);
  endproperty
  a_level_gate: assert property (p_level_gate) else $error("port driven with level off");

  property p_duty_off;
    (pwm_run && pair_q[0][7:4] != PIB_LEVEL_STATIC && slot_q > pair_q[0][7:4])
      |=> !port_drive_q[1];
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("port 1 on past its slots");

  property p_duty_off_port0;
    (pwm_run && pair_q[0][3:0] != PIB_LEVEL_STATIC && slot_q > pair_q[0][3:0])
      |=> !port_drive_q[0];
  endproperty
  a_duty_off_port0: assert property (p_duty_off_port0) else $error("port 0 on too long");

  property p_duty_on;
    (pwm_run && slot_q <= pair_q[0][3:0]) |=> (port_drive_q[0] == $past(port_level[0]));
  endproperty
  a_duty_on: assert property (p_duty_on) else $error("port 0 off inside its slots");
endmodule : pib_port_intensity_bank

// ### verilog/pib_pkg.sv
// Package with register codes, field layout and reset values of the intensity bank
package pib_pkg;
  localparam int PIB_ADDR_W = 8;
  localparam int PIB_DATA_W = 8;
  localparam int PIB_LEVEL_W = 4;
  localparam int PIB_PORTS = 8;
  localparam int PIB_PAIRS = 4;
  localparam int PIB_SLOTS = 16;
  localparam logic [7:0] PIB_ADDR_PAIR_1_0 = 8'h10;
  localparam logic [7:0] PIB_ADDR_PAIR_3_2 = 8'h11;
  localparam logic [7:0] PIB_ADDR_PAIR_5_4 = 8'h12;
  localparam logic [7:0] PIB_ADDR_PAIR_7_6 = 8'h13;
  localparam int PIB_HI_LSB = 4;
  localparam int PIB_LO_LSB = 0;
  localparam logic [7:0] PIB_PAIR_RESET = 8'hFF;
  localparam logic [3:0] PIB_LEVEL_STATIC = 4'hF;
  localparam logic [3:0] PIB_MASTER_OFF = 4'h0;
  localparam logic [3:0] PIB_SLOT_LAST = 4'hF;
  localparam int PIB_SLOT_CYCLES = 1;
  typedef logic [7:0] pib_pair_t;
endpackage : pib_pkg

// ### verilog/pib_slot_counter.sv
// Shared sixteen-slot PWM slot counter
`timescale 1ns/1ps
module pib_slot_counter #(
  parameter int SLOT_CYCLES = pib_pkg::PIB_SLOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  pib_slot_if.counter slot_bus
);
  import pib_pkg::*;

  logic run;
  logic [3:0] slot_q;
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic [3:0] slot_d;

  assign run = slot_bus.run;
  assign slot_bus.slot_q = slot_q;

  always_comb begin
    div_d = div_q;
    slot_d = slot_q;
    if (!run) begin
      // Oscillator stopped: park at slot zero so restart is clean
      div_d = 16'h0000;
      slot_d = 4'h0;
    end else if (div_q == 16'(SLOT_CYCLES - 1)) begin
      div_d = 16'h0000;
      slot_d = (slot_q == PIB_SLOT_LAST) ? 4'h0 : 4'(slot_q + 4'h1);
    end else begin
      div_d = 16'(div_q + 16'h0001);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 16'h0000;
      slot_q <= 4'h0;
    end else begin
      div_q <= div_d;
      slot_q <= slot_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_slot_wrap;
    (run && slot_q == PIB_SLOT_LAST && div_q == 16'(SLOT_CYCLES - 1)) |=> (slot_q == 4'h0);
  endproperty
  a_slot_wrap: assert property (p_slot_wrap) else $error("slot counter did not wrap");

  property p_slot_park;
    !run |=> (slot_q == 4'h0);
  endproperty
  a_slot_park: assert property (p_slot_park) else $error("slot counter ran while stopped");
endmodule : pib_slot_counter

// ### verilog/unused_placeholder_none.sv
// Interface carrying the run request and slot count between the bank and its counter
`timescale 1ns/1ps
interface pib_slot_if;
  logic run;
  logic [3:0] slot_q;
  modport counter (
    input run,
    output slot_q
  );
  modport bank (
    output run,
    input slot_q
  );
endinterface : pib_slot_if

// ### verification/pib_host_model.sv
// Host-side model that drives the intensity bank register strobe port
`timescale 1ns/1ps
module pib_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data_q,
  input wire logic reg_rd_hit_q
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Released lines show the inverse, so a stale address or data cannot pass as fresh
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rd_data_q;
    h = reg_rd_hit_q;
  endtask : rd
  // Write then read the same code on the very next edge, as the strobe port allows
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic h);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_wr_data = ~d;
    reg_rd_en = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    q = reg_rd_data_q;
    h = reg_rd_hit_q;
  endtask : wr_rd
endmodule : pib_host_model

// ### verification/tb.sv
// Self-checking testbench for the port intensity PWM bank
`timescale 1ns/1ps
module tb;
  import pib_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] master_level = 4'h8;
  logic [7:0] port_level = 8'hFF;
  logic [7:0] addr, wr_data, rd_data_q, port_drive_q;
  logic wr_en, rd_en, rd_hit_q;
  logic [3:0] codes [8] = '{4'h0, 4'hE, 4'h7, 4'hF, 4'hB, 4'h3, 4'hD, 4'hF};
  int err_count = 0;
  int compares = 0;
  pib_port_intensity_bank i_pib_port_intensity_bank (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wr_data), .reg_rd_en(rd_en),
    .reg_rd_data_q(rd_data_q), .reg_rd_hit_q(rd_hit_q), .master_level(master_level),
    .port_level(port_level), .port_drive_q(port_drive_q));
  pib_host_model i_pib_host_model (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data_q(rd_data_q),
    .reg_rd_hit_q(rd_hit_q));
  initial forever #25 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    logic [7:0] d;
    logic h;
    i_pib_host_model.rd(a, d, h);
    chk($sformatf("data at %h", a), exp, d);
    chk($sformatf("hit at %h", a), {7'h00, hit}, {7'h00, h});
  endtask : rd_chk
  task automatic t_reset();
    for (int i = 0; i < 4; i++) rd_chk(8'h10 + 8'(i), PIB_PAIR_RESET, 1'b1);
  endtask : t_reset
  task automatic t_regs();
    logic [7:0] v [4] = '{8'h1E, 8'h72, 8'hC3, 8'h0D};
    logic [7:0] d;
    logic h;
    for (int i = 0; i < 4; i++) i_pib_host_model.wr(8'h10 + 8'(i), v[i]);
    i_pib_host_model.wr(8'h0E, 8'h33);
    i_pib_host_model.wr(8'h14, 8'h44);
    for (int i = 0; i < 4; i++) rd_chk(8'h10 + 8'(i), v[i], 1'b1);
    rd_chk(8'h0E, 8'h00, 1'b0);
    rd_chk(8'h04, 8'h00, 1'b0);
    i_pib_host_model.wr_rd(8'h13, 8'h5A, d, h);
    chk("back-to-back data", 8'h5A, d);
    chk("back-to-back hit", 8'h01, {7'h00, h});
  endtask : t_regs
  task automatic t_duty();
    logic [7:0] cnt [8];
    logic [7:0] exp;
    for (int i = 0; i < 4; i++) i_pib_host_model.wr(8'h10 + 8'(i), {codes[2*i+1], codes[2*i]});
    // Port 7 is off at full code, so a static low must show no PWM
    port_level = 8'h7F;
    master_level = 4'h8;
    repeat (20) @(posedge ref_clk);
    for (int p = 0; p < 8; p++) cnt[p] = 8'h00;
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      #1;
      for (int p = 0; p < 8; p++) cnt[p] = cnt[p] + {7'h00, port_drive_q[p]};
    end
    for (int p = 0; p < 8; p++) begin
      exp = !port_level[p] ? 8'h00 : (codes[p] == PIB_LEVEL_STATIC) ? 8'h10 : codes[p] + 8'h01;
      chk($sformatf("active slots port %0d", p), exp, cnt[p]);
    end
  endtask : t_duty
  task automatic t_master_off();
    @(posedge ref_clk);
    #1;
    master_level = PIB_MASTER_OFF;
    port_level = 8'hA5;
    repeat (3) @(posedge ref_clk);
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      #1;
      chk("static drive", 8'hA5, port_drive_q);
    end
  endtask : t_master_off
  task automatic t_mid_reset();
    @(posedge ref_clk);
    #1;
    reset_n = 1'b0;
    #1;
    chk("drive in reset", 8'h00, port_drive_q);
    repeat (3) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) rd_chk(8'h10 + 8'(i), PIB_PAIR_RESET, 1'b1);
    chk("drive after reset", 8'hA5, port_drive_q);
  endtask : t_mid_reset
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_duty();
    t_master_off();
    t_mid_reset();
    stop_test();
  end
endmodule : tb
